// ---- rtl/nvrtc_host.v ----
`timescale 1ns/1ps
`include "nvrtc_regs.vh"
module nvrtc_host #(
  parameter AW = 19
) (
  // Clock and reset.
  input  wire          sys_clk_i,
  input  wire          rst_b_i,
  // User command.
  input  wire          cmd_valid_i,
  output wire          cmd_ready_o,
  input  wire [1:0]    cmd_op_i,
  input  wire [AW-1:0] cmd_addr_i,
  input  wire [7:0]    cmd_wdata_i,
  input  wire [63:0]   cmd_clk_wdata_i,
  // RAM read answers through the FIFO; clock read answers on clk_rdata_o.
  output wire          rsp_valid_o,
  input  wire          rsp_ready_i,
  output wire [7:0]    rsp_data_o,
  output reg  [63:0]   clk_rdata_o,
  output reg           clk_done_o,
  // Device pins.
  output reg  [AW-1:0] address_lines_o,
  output reg           ce_b_o,
  output reg           oe_b_o,
  output reg           we_b_o,
  input  wire [7:0]    dq_i,
  output reg  [7:0]    dq_o,
  output reg           dq_oe_o,
  input  wire          power_ok_i
);
  // Counts are worked out as integers, then cut to the four bits that the timer holds.
  localparam integer NSET_W = `NVRTC_CYC(`NVRTC_T_SETUP_NS);
  localparam integer NPUL_W = `NVRTC_CYC(`NVRTC_T_PULSE_NS);
  localparam integer NREC_W = `NVRTC_CYC(`NVRTC_T_RECOV_NS);
  localparam [3:0] NSET = NSET_W[3:0];
  localparam [3:0] NPUL = NPUL_W[3:0];
  localparam [3:0] NREC = NREC_W[3:0];
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SET  = 5'h02;
  localparam [4:0] S_PUL  = 5'h04;
  localparam [4:0] S_REC  = 5'h08;
  localparam [4:0] S_NEXT = 5'h10;
  localparam [1:0] PH_SINGLE = 2'h0;
  localparam [1:0] PH_OPEN   = 2'h1;
  localparam [1:0] PH_KEY    = 2'h2;
  localparam [1:0] PH_DATA   = 2'h3;
  reg [4:0]    st_q;
  reg [3:0]    tmr_q;
  reg [1:0]    ph_q;
  reg [6:0]    idx_q;
  reg          rd_q;
  reg          clkop_q;
  reg          rdsel_q;
  reg [63:0]   sh_q;
  reg [7:0]    wd_q;
  wire         f_ready;
  wire         f_push = st_q[2] && tmr_q == 4'h1 && rd_q && ph_q == PH_SINGLE;
  wire [63:0]  key = `NVRTC_KEY;
  nvrtc_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (f_push),
    .in_ready_o  (f_ready),
    .in_data_i   (dq_i),
    .out_valid_o (rsp_valid_o),
    .out_ready_i (rsp_ready_i),
    .out_data_o  (rsp_data_o)
  );
  // Commands stall when the device is powered down or the answer FIFO is full.
  assign cmd_ready_o = st_q[0] && power_ok_i && f_ready;
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_q            <= S_IDLE;
      tmr_q           <= 4'h0;
      ph_q            <= PH_SINGLE;
      idx_q           <= 7'h0;
      rd_q            <= 1'b0;
      clkop_q         <= 1'b0;
      sh_q            <= 64'h0;
      wd_q            <= 8'h00;
      address_lines_o <= {AW{1'b0}};
      ce_b_o          <= 1'b1;
      oe_b_o          <= 1'b1;
      we_b_o          <= 1'b1;
      dq_o            <= 8'h00;
      dq_oe_o         <= 1'b0;
      clk_rdata_o     <= 64'h0;
      clk_done_o      <= 1'b0;
    end else begin
      clk_done_o <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            address_lines_o <= cmd_addr_i;
            clkop_q         <= cmd_op_i[1];
            rd_q            <= (cmd_op_i == `NVRTC_CMD_RAM_RD) || cmd_op_i[1];
            ph_q            <= cmd_op_i[1] ? PH_OPEN : PH_SINGLE;
            sh_q            <= cmd_clk_wdata_i;
            wd_q            <= cmd_wdata_i;
            idx_q           <= 7'h0;
            tmr_q           <= NSET;
            st_q            <= S_SET;
          end
        end
        S_SET: begin
          // Output enable never falls during a write, so the data bus never fights the device.
          dq_oe_o <= !rd_q;
          dq_o    <= (ph_q == PH_KEY) ? {7'h0, key[idx_q[5:0]]} :
                     (ph_q == PH_DATA) ? {7'h0, sh_q[0]} : wd_q;
          ce_b_o  <= 1'b0;
          if (tmr_q == 4'h1) begin
            oe_b_o <= !rd_q;
            we_b_o <= rd_q;
            tmr_q  <= NPUL;
            st_q   <= S_PUL;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        S_PUL: begin
          if (tmr_q == 4'h1) begin
            if (ph_q == PH_DATA) begin
              sh_q <= {(rd_q ? dq_i[0] : sh_q[0]), sh_q[63:1]};
            end
            ce_b_o <= 1'b1;
            oe_b_o <= 1'b1;
            we_b_o <= 1'b1;
            tmr_q  <= NREC;
            st_q   <= S_REC;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        S_REC: begin
          dq_oe_o <= 1'b0;
          if (tmr_q == 4'h1) begin
            st_q <= S_NEXT;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        S_NEXT: begin
          st_q  <= S_SET;
          tmr_q <= NSET;
          case (ph_q)
            PH_OPEN: begin
              // Key writes also land in RAM at the given scratch address.
              ph_q  <= PH_KEY;
              rd_q  <= 1'b0;
              idx_q <= 7'h0;
            end
            PH_KEY: begin
              if (idx_q == `NVRTC_KEY_BITS - 1) begin
                ph_q  <= PH_DATA;
                rd_q  <= clkop_q && rdsel_q;
                idx_q <= 7'h0;
              end else begin
                idx_q <= idx_q + 7'h1;
              end
            end
            PH_DATA: begin
              if (idx_q == `NVRTC_XFER_BITS - 1) begin
                // Back to plain memory mode; another clock access repeats the unlock.
                clk_rdata_o <= sh_q;
                clk_done_o  <= 1'b1;
                ph_q        <= PH_SINGLE;
                st_q        <= S_IDLE;
              end else begin
                idx_q <= idx_q + 7'h1;
              end
            end
            default: begin
              st_q <= S_IDLE;
            end
          endcase
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rdsel_q <= 1'b0;
    end else if (st_q[0] && cmd_valid_i && cmd_ready_o) begin
      rdsel_q <= (cmd_op_i == `NVRTC_CMD_CLK_RD);
    end
  end
endmodule // nvrtc_host

// ---- rtl/nvrtc_regs.vh ----
// Functional notes
// - Address stable; write-enable recovers before next.
// - Output enable high during every write.
// - Unlock opens with one read cycle.
// - Key C5 3A A3 5C twice, LSB first.
// - Registers handled in whole bytes only.
`ifndef NVRTC_REGS_VH
`define NVRTC_REGS_VH
`define NVRTC_KEY            64'h5ca3_3ac5_5ca3_3ac5
`define NVRTC_KEY_BITS       64
`define NVRTC_XFER_BITS      64
`define NVRTC_REG_HOURS      3
`define NVRTC_REG_DAY        4
`define NVRTC_HOURS_12H_BIT  7
`define NVRTC_HOURS_PM_BIT   5
`define NVRTC_DAY_ABORT_BIT  4
`define NVRTC_DAY_OSC_BIT    5
`define NVRTC_DAY_RESET      8'h30
`define NVRTC_CMD_RAM_RD     2'h0
`define NVRTC_CMD_RAM_WR     2'h1
`define NVRTC_CMD_CLK_RD     2'h2
`define NVRTC_CMD_CLK_WR     2'h3
`define NVRTC_T_SETUP_NS     30
`define NVRTC_T_PULSE_NS     70
`define NVRTC_T_RECOV_NS     20
`define NVRTC_CLK_MHZ        100
`define NVRTC_CYC(ns)        (((ns) * `NVRTC_CLK_MHZ + 999) / 1000)
`endif

// ---- rtl/nvrtc_fifo.v ----
`timescale 1ns/1ps
module nvrtc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset.
  input  wire             sys_clk_i,
  input  wire             rst_b_i,
  // Fill side.
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side.
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push = in_valid_i && in_ready_o;
  wire            pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
    if (!rst_b_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // nvrtc_fifo

// ---- testbench/nvrtc_host_props.sv ----
`timescale 1ns/1ps
module nvrtc_host_props #(parameter AW = 19) (
  // Clock, reset and power.
  input wire          sys_clk_i,
  input wire          rst_b_i,
  input wire          power_ok_i,
  // Host outputs.
  input wire          cmd_ready_o,
  input wire          clk_done_o,
  input wire [AW-1:0] address_lines_o,
  input wire          ce_b_o,
  input wire          oe_b_o,
  input wire          we_b_o,
  input wire          dq_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence wr_pulse; !we_b_o [*7]; endsequence
  sequence wr_recov; we_b_o [*2]; endsequence
  sequence wr_held; (!we_b_o && !ce_b_o) ##1 (!we_b_o && !ce_b_o); endsequence
  a_wr_width: assert property ($fell(we_b_o) |-> wr_pulse) else $error("write pulse short");
  a_wr_recovery: assert property ($rose(we_b_o) |-> wr_recov) else $error("write recovery short");
  a_addr_hold: assert property (wr_held |-> $stable(address_lines_o)) else $error("address moved");
  a_no_fight: assert property (!(!oe_b_o && !we_b_o)) else $error("output and write enable both low");
  a_rd_release: assert property (!oe_b_o |-> !dq_oe_o) else $error("host drives during read");
  a_wr_drive: assert property (!we_b_o |-> dq_oe_o) else $error("write without data driven");
  a_pwr_refuse: assert property (!power_ok_i |-> !cmd_ready_o) else $error("ready while power low");
  a_done_pulse: assert property (clk_done_o |=> !clk_done_o) else $error("done longer than a cycle");
endmodule // nvrtc_host_props
bind nvrtc_host nvrtc_host_props #(.AW(AW)) nvrtc_host_props_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .power_ok_i(power_ok_i), .cmd_ready_o(cmd_ready_o), .clk_done_o(clk_done_o), .address_lines_o(address_lines_o),
  .ce_b_o(ce_b_o), .oe_b_o(oe_b_o), .we_b_o(we_b_o), .dq_oe_o(dq_oe_o));

// ---- testbench/nvrtc_dev_model.sv ----
`timescale 1ns/1ps
`include "nvrtc_regs.vh"
module nvrtc_dev_model (
  // Device pins.
  input  wire [18:0] address_lines_i,
  input  wire        ce_b_i,
  input  wire        oe_b_i,
  input  wire        we_b_i,
  input  wire [7:0]  dq_i,
  output wire [7:0]  dq_o,
  input  wire        power_ok_i
);
  localparam [63:0] key = `NVRTC_KEY;
  reg  [7:0]  mem [0:524287];
  reg  [63:0] clk_q = {24'h0, `NVRTC_DAY_RESET, 32'h0};
  reg  [6:0]  ptr_q = 7'h0;
  reg         miss_q = 1'b1;
  reg         xfer_q = 1'b0;
  reg  [7:0]  last_q = 8'h00;
  wire        rd = !ce_b_i && !oe_b_i && we_b_i && power_ok_i;
  wire        wr = !ce_b_i && !we_b_i && power_ok_i;
  wire [7:0]  rdv = xfer_q ? {7'h0, clk_q[ptr_q[5:0]]} : mem[address_lines_i];
  // A released bus shows the inverse of the last byte, so a late sample cannot pass by luck.
  assign dq_o = rd ? rdv : ~last_q;
  task step;
    ptr_q = ptr_q + 7'h1;
    if (ptr_q == 7'h40) begin
      xfer_q = 1'b0;
      ptr_q = 7'h0;
      miss_q = 1'b1;
    end
  endtask
  always @(negedge rd) begin
    last_q = rdv;
    if (xfer_q) step;
    else begin
      ptr_q = 7'h0;
      miss_q = 1'b0;
    end
  end
  always @(negedge wr) begin
    if (xfer_q) begin
      clk_q[ptr_q[5:0]] = dq_i[0];
      step;
    end else begin
      mem[address_lines_i] = dq_i;
      if (!miss_q && dq_i[0] === key[ptr_q[5:0]]) ptr_q = ptr_q + 7'h1;
      else miss_q = 1'b1;
      if (ptr_q == 7'h40) begin
        xfer_q = 1'b1;
        ptr_q = 7'h0;
      end
    end
  end
endmodule // nvrtc_dev_model

// ---- testbench/nvrtc_host_tb_top.sv ----
`timescale 1ns/1ps
`include "nvrtc_regs.vh"
module nvrtc_host_tb_top;
  localparam [63:0] img = 64'h9912_2835_b145_5999;
  reg         clk, rst_b, vld, rrdy, pwr;
  reg  [1:0]  op;
  reg  [18:0] addr;
  reg  [7:0]  wd;
  reg  [63:0] cw;
  wire        rdy, rv, done, ce_b, oe_b, we_b, dq_oe;
  wire [7:0]  rdat, hdq, ddq;
  wire [63:0] crd;
  wire [18:0] al;
  wire [7:0]  dqw = dq_oe ? hdq : ddq;
  int         err_total = 0;
  int         num_checks = 0;
  int         k;
  nvrtc_host nvrtc_host_inst (.sys_clk_i(clk), .rst_b_i(rst_b), .cmd_valid_i(vld), .cmd_ready_o(rdy),
    .cmd_op_i(op), .cmd_addr_i(addr), .cmd_wdata_i(wd), .cmd_clk_wdata_i(cw), .rsp_valid_o(rv),
    .rsp_ready_i(rrdy), .rsp_data_o(rdat), .clk_rdata_o(crd), .clk_done_o(done), .address_lines_o(al),
    .ce_b_o(ce_b), .oe_b_o(oe_b), .we_b_o(we_b), .dq_i(dqw), .dq_o(hdq), .dq_oe_o(dq_oe), .power_ok_i(pwr));
  nvrtc_dev_model nvrtc_dev_model_inst (.address_lines_i(al), .ce_b_i(ce_b), .oe_b_i(oe_b), .we_b_i(we_b),
    .dq_i(dqw), .dq_o(ddq), .power_ok_i(pwr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A clock op is 129 bus cycles of 13 clocks, so 3000 leaves margin yet still cuts a hang.
  task wait_on(input bit w);
    int n;
    for (n = 0; n < 3000 && (w ? done : rdy) !== 1'b1; n++) tick;
    if ((w ? done : rdy) !== 1'b1) begin
      err_total++;
      print_verdict;
    end
  endtask
  task send(input [1:0] o, input [18:0] a, input [7:0] d, input [63:0] c);
    wait_on(1'b0);
    {op, addr, wd, cw} = {o, a, d, c};
    vld = 1'b1;
    tick;
    vld = 1'b0;
  endtask
  task clk_op(input [1:0] o, input [63:0] c);
    send(o, 19'h00100, 8'h00, c);
    wait_on(1'b1);
  endtask
  initial begin
    {vld, op, addr, wd, cw, rst_b, rrdy, pwr} = {94'h0, 3'b011};
    repeat (10) tick;
    rst_b = 1'b1;
    clk_op(2'h2, 64'h0);
    chk(crd, {24'h0, `NVRTC_DAY_RESET, 32'h0});
    chk(crd[32 + `NVRTC_DAY_ABORT_BIT], 1'b1);
    clk_op(2'h3, img);
    chk(nvrtc_dev_model_inst.mem[19'h00100], `NVRTC_KEY >> 63);
    clk_op(2'h2, 64'h0);
    chk(crd, img);
    chk(crd[31:24], 8'hb1);
    $display("test timekeeper done");
    for (k = 0; k < 4; k++) send(2'h1, 19'h40000 >> k, 8'h11 << k, 64'h0);
    rrdy = 1'b0;
    for (k = 0; k < 4; k++) send(2'h0, 19'h40000 >> k, 8'h00, 64'h0);
    repeat (20) tick;
    chk(rdy, 1'b0);
    rrdy = 1'b1;
    for (k = 0; k < 4; k++) begin
      chk({rv, rdat}, {1'b1, 8'h11 << k});
      tick;
    end
    chk(rv, 1'b0);
    $display("test ram done");
    pwr = 1'b0;
    tick;
    chk(rdy, 1'b0);
    pwr = 1'b1;
    $display("test power done");
    print_verdict;
  end
endmodule // nvrtc_host_tb_top
